// file: usb_suspend_pkg.sv
// Package for the USB suspend state control block.
// Assumes one 40 MHz clock domain and USB event detection done upstream.
package usb_suspend_pkg;
    localparam int unsigned gpio_width = 8;
    localparam logic suspend_reset_value = 1'b1;

    // USB bus events as delivered by the serial interface engine, one-cycle pulses.
    typedef struct packed {
        logic suspend_detected;
        logic resume_detected;
        logic resume_generated;
        logic bus_reset_detected;
        logic config_done;
    } usb_event_type;

    // Suspend indicator pins, each split into level and enable.
    typedef struct packed {
        logic suspend_out;
        logic suspend_oe;
        logic suspend_n_out;
        logic suspend_n_oe;
        logic pull_up_enable;
    } indicator_type;

    typedef struct packed {
        logic [gpio_width-1:0] level;
        logic [gpio_width-1:0] direction;
    } gpio_type;

    typedef enum logic [1:0] {
        st_unconfigured,
        st_active,
        st_suspended
    } power_state_type;
endpackage

// file: usb_suspend_state_control.sv
// Suspend and resume state control with suspend indicator pins and GPIO hold.
// Assumes USB events arrive as synchronous pulses and data paths sit outside.
// Operation
// - Host commands pass to SMBus with valid blocked while suspended; GPIO requests pass except while suspended.
// - Enter suspend from normal operation when suspend signaling is detected on the USB bus with no bus reset in the same cycle.
// - Both suspend indicators assert at the moment suspend is entered.
// - After device reset, indicators stay asserted until enumeration configuration completes.
// - Active-high indicator is 1 while suspended, 0 in normal operation.
// - Active-low indicator is always the complement of the active-high one.
// - Leave suspend on resume detected or generated, bus reset, or device reset.
// - During device reset both indicators float with a weak pull to io_supply_rail.
// - GPIO level and direction are held unchanged while suspended.
`timescale 1ns/1ps
`default_nettype none
module usb_suspend_state_control
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire usb_suspend_pkg::usb_event_type usb_event,
    input wire logic [7:0] host_cmd_data,
    input wire logic host_cmd_valid,
    output logic [7:0] smbus_cmd_data,
    output logic smbus_cmd_valid,
    input wire usb_suspend_pkg::gpio_type gpio_request,
    output usb_suspend_pkg::gpio_type gpio_drive,
    output usb_suspend_pkg::indicator_type indicator,
    output logic low_power
);
    import usb_suspend_pkg::*;

    power_state_type state;
    power_state_type next_state;
    logic suspended;
    logic next_suspended;
    gpio_type next_gpio_drive;
    logic [7:0] next_smbus_cmd_data;
    logic next_smbus_cmd_valid;

    always_comb
    begin
        next_state = state;
        unique case (state)
            st_unconfigured:
            begin
                if (usb_event.config_done)
                begin
                    next_state = st_active;
                end
            end
            st_active:
            begin
                if (usb_event.bus_reset_detected)
                begin
                    next_state = st_unconfigured;
                end
                else if (usb_event.suspend_detected)
                begin
                    next_state = st_suspended;
                end
            end
            st_suspended:
            begin
                // A bus reset returns to enumeration, so indicators stay asserted until reconfigured.
                if (usb_event.bus_reset_detected)
                begin
                    next_state = st_unconfigured;
                end
                else if (usb_event.resume_detected || usb_event.resume_generated)
                begin
                    next_state = st_active;
                end
            end
        endcase
        next_suspended = (next_state != st_active);
    end

    always_comb
    begin
        next_gpio_drive = gpio_drive;
        if (next_state != st_suspended)
        begin
            next_gpio_drive = gpio_request;
        end
        // GPIO follows the request only when the coming state is not suspended.
        next_smbus_cmd_data = host_cmd_valid ? host_cmd_data : smbus_cmd_data;
        next_smbus_cmd_valid = host_cmd_valid && (state != st_suspended);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= st_unconfigured;
            suspended <= suspend_reset_value;
            gpio_drive <= '0;
            smbus_cmd_data <= 8'h00;
            smbus_cmd_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            state <= next_state;
            suspended <= next_suspended;
            gpio_drive <= next_gpio_drive;
            smbus_cmd_data <= next_smbus_cmd_data;
            smbus_cmd_valid <= next_smbus_cmd_valid;
        end
    end

    // Reset gating is combinational on rstn so the pins float at once, not one edge late.
    always_comb
    begin
        indicator.suspend_out = suspended;
        indicator.suspend_n_out = ~suspended;
        indicator.suspend_oe = rstn;
        indicator.suspend_n_oe = rstn;
        indicator.pull_up_enable = ~rstn;
    end

    assign low_power = (state == st_suspended);
endmodule
`default_nettype wire

// file: usb_host_model.sv
// Host model turning a code into bus event pulses, two for code 5 and none for codes 6 and 7.
// Codes change at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
(
    input wire logic [2:0] op,
    output usb_suspend_pkg::usb_event_type usb_event
);
    // Code 5 sends a bus reset together with suspend.
    assign usb_event = op == 3'h5 ? 5'h12 : op < 3'h5 ? 5'h10 >> op : 5'h00;
endmodule
`default_nettype wire

// file: usb_suspend_monitor.sv
// Checker tying the suspend indicators to their bus events.
// Bound to the state control block.
`timescale 1ns/1ps
`default_nettype none
module usb_suspend_monitor
(
    input wire logic clk,
    input wire logic rstn,
    input wire usb_suspend_pkg::usb_event_type usb_event,
    input wire usb_suspend_pkg::indicator_type indicator,
    input wire logic low_power
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic s = indicator.suspend_out, d = usb_event.suspend_detected;
    wire logic b = usb_event.bus_reset_detected, f = usb_event.config_done;
    wire logic r = usb_event.resume_detected || usb_event.resume_generated;
    AST_ENTER: assert property ($rose(low_power) |-> $past(d && !b)) else $error("entry");
    AST_LEAVE: assert property ($fell(low_power) |-> $past(r || b)) else $error("leave");
    AST_RAISE: assert property ($rose(s) |-> $past(d || b)) else $error("raise");
    AST_CLEAR: assert property ($fell(s) |-> $past(r || f)) else $error("clear");
    AST_PAIR: assert property (indicator.suspend_n_out != s) else $error("pair");
    AST_PINS: assert property (indicator.suspend_oe && indicator.suspend_n_oe)
        else $error("pins");
endmodule
bind usb_suspend_state_control usb_suspend_monitor i_mon (.*);
`default_nettype wire

// file: tb.sv
// Random host events checked against a model of the power state.
// Inputs change at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import usb_suspend_pkg::*;
    logic clk = 0, rstn = 0, clk_en = 1, host_cmd_valid = 0, smbus_cmd_valid, low_power;
    logic [2:0] op = 3'h7;
    logic [7:0] host_cmd_data = 8'h00, smbus_cmd_data;
    gpio_type gpio_request = '0, gpio_drive, g = '0;
    usb_event_type usb_event;
    indicator_type indicator;
    int seed = 38, fails = 0, n_compared = 0, s = 0;
    logic v = 0;
    logic [7:0] dd = 8'h00;
    usb_host_model i_host (.*);
    usb_suspend_state_control i_dut (.*);
    initial forever #12.5 clk = ~clk;
    function int nxt(int t, usb_event_type u);
        if (u.bus_reset_detected) return 0;
        if (t == 0) return u.config_done;
        if (t == 1) return 1 + u.suspend_detected;
        return 2 - (u.resume_detected | u.resume_generated);
    endfunction
    task chk(input logic [18:0] a, b);
        n_compared++;
        fails += (a !== b);
        if (a !== b) $display("mismatch %0t %h %h", $time, a, b);
    endtask
    task end_sim;
        $display("fails %0d compared %0d", fails, n_compared);
        if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #1 chk({indicator.suspend_oe, indicator.pull_up_enable}, 19'h1);
        repeat (2) @(negedge clk);
        rstn = 1;
        for (int i = 0; i < 3000; i++)
        begin
            @(negedge clk);
            // A mid-run reset spans one rising edge so the checker sees it.
            if (i == 1500)
            begin
                rstn = 0;
                #1 chk({indicator.suspend_oe, indicator.pull_up_enable}, 19'h1);
                @(negedge clk);
                rstn = 1;
                s = 0;
                g = '0;
                v = 0;
                dd = 8'h00;
            end
            else if (clk_en)
            begin
                v = host_cmd_valid && s != 2;
                if (host_cmd_valid) dd = host_cmd_data;
                s = nxt(s, usb_event);
                if (s != 2) g = gpio_request;
            end
            chk({indicator.suspend_out, indicator.suspend_n_out, low_power, gpio_drive},
                {s != 1, s == 1, s == 2, g});
            chk({smbus_cmd_valid, smbus_cmd_data}, {v, dd});
            // The first codes walk configure, suspend, resume, suspend and a bus reset out of suspend; code 5 comes while unconfigured.
            op = i < 8 ? 3'(24'hE2B084 >> 3 * i) : 3'($random(seed));
            clk_en = i < 8 || 3'($random(seed)) != 3'h0;
            {host_cmd_valid, host_cmd_data, gpio_request} = 25'($random(seed));
        end
        end_sim;
    end
endmodule
`default_nettype wire
